/* hdl/irh_top.sv */
// two-wire bus receive path: stop interrupt mask, handshake reception, ready flag
// assumes axi4-lite master on sys_clk; scl and sda arrive asynchronously
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "irh_cfg.svh"
module irh_top (
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   nrst,
	// axi4-lite write
	input  wire logic [`IRH_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire irh_pkg::irh_word_t     s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// axi4-lite read
	input  wire logic [`IRH_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output irh_pkg::irh_word_t          s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// bus pins
	input  wire logic                   scl_i,
	output logic                        scl_o,
	output logic                        scl_oe,
	input  wire logic                   sda_i,
	// interrupt
	output logic                        irq
);
	import irh_pkg::*;

	// reset release through two flops
	logic rst_m_q, rst_n_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// pin synchronisers; only the second stage and later are read
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// bus slave state
	logic                   awrdy_q, awrdy_d, wrdy_q, wrdy_d;
	logic                   awful_q, awful_d, wful_q, wful_d;
	logic [`IRH_ADDR_W-1:0] waddr_q, waddr_d;
	irh_word_t              wdata_q, wdata_d;
	logic                   wstb_q, wstb_d; // lane 0 strobe, taken with its data
	logic                   bval_q, bval_d;
	logic [1:0]             bresp_q, bresp_d;
	logic                   arrdy_q, arrdy_d, rval_q, rval_d;
	irh_word_t              rdata_q, rdata_d;
	logic [1:0]             rresp_q, rresp_d;
	// block state
	logic [1:0]             ext_q, ext_d;
	logic [2:0]             ctrl_q, ctrl_d;
	logic [1:0]             stat_q, stat_d, imask_q, imask_d;
	logic                   flag_q, flag_d, pend_q, pend_d;
	logic                   xfer_q, xfer_d, irq_q, irq_d;
	logic                   oe_q, oe_d;
	logic [7:0]             shift_q, shift_d, rbuf_q, rbuf_d;
	logic [3:0]             cnt_q, cnt_d;
	irh_rx_st_t             st_q, st_d;
	// decoded events
	logic                   wr_go, rd_go, rd_hit, st_hit, clr_c;
	logic                   rx_on, rise, start_c, stop_c, done_c, flag_eff;
	logic [`IRH_ADDR_W-1:0] wa;
	irh_word_t              wd;

	// a write commits once address and data are both held
	always_comb begin
		awful_d = awful_q | (s_axi_awvalid & awrdy_q);
		wful_d  = wful_q | (s_axi_wvalid & wrdy_q);
		waddr_d = (s_axi_awvalid & awrdy_q) ? s_axi_awaddr : waddr_q;
		wdata_d = (s_axi_wvalid & wrdy_q) ? s_axi_wdata : wdata_q;
		wstb_d  = (s_axi_wvalid & wrdy_q) ? s_axi_wstrb[0] : wstb_q;
		wr_go   = awful_d & wful_d & ~bval_q;
		wa      = waddr_d;
		wd      = wdata_d;
		bval_d  = wr_go | (bval_q & ~s_axi_bready);
		bresp_d = bresp_q;
		if (wr_go) begin
			awful_d = 1'b0;
			wful_d  = 1'b0;
			if (wa == `IRH_OFF_EXT || wa == `IRH_OFF_CTRL || wa == `IRH_OFF_CLR
				|| wa == `IRH_OFF_MASK) begin
				bresp_d = `IRH_RESP_OK;
			end else begin
				bresp_d = `IRH_RESP_ERR;
			end
		end
		awrdy_d = ~awful_d & ~bval_d;
		wrdy_d  = ~wful_d & ~bval_d;
		// read: one outstanding, data registered with the answer
		rd_go   = s_axi_arvalid & arrdy_q;
		rval_d  = rd_go | (rval_q & ~s_axi_rready);
		arrdy_d = ~rval_d;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		rd_hit  = rd_go & (s_axi_araddr == `IRH_OFF_DATA);
		st_hit  = rd_go & (s_axi_araddr == `IRH_OFF_STAT);
		if (rd_go) begin
			rdata_d = '0;
			rresp_d = `IRH_RESP_OK;
			if (s_axi_araddr == `IRH_OFF_EXT) begin
				rdata_d[7:5] = {ext_q, flag_q};
			end else if (s_axi_araddr == `IRH_OFF_CTRL) begin
				rdata_d[2:0] = ctrl_q;
			end else if (s_axi_araddr == `IRH_OFF_DATA) begin
				rdata_d[7:0] = rbuf_q;
			end else if (s_axi_araddr == `IRH_OFF_CLR) begin
				rdata_d[3:0] = 4'hf; // code field always reads ones
			end else if (s_axi_araddr == `IRH_OFF_STAT) begin
				rdata_d[1:0] = stat_q;
			end else if (s_axi_araddr == `IRH_OFF_MASK) begin
				rdata_d[1:0] = imask_q;
			end else begin
				rresp_d = `IRH_RESP_ERR;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			awrdy_q <= 1'b0;
			wrdy_q  <= 1'b0;
			awful_q <= 1'b0;
			wful_q  <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
			wstb_q  <= 1'b0;
			bval_q  <= 1'b0;
			bresp_q <= `IRH_RESP_OK;
			arrdy_q <= 1'b0;
			rval_q  <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `IRH_RESP_OK;
		end else begin
			awrdy_q <= awrdy_d;
			wrdy_q  <= wrdy_d;
			awful_q <= awful_d;
			wful_q  <= wful_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstb_q  <= wstb_d;
			bval_q  <= bval_d;
			bresp_q <= bresp_d;
			arrdy_q <= arrdy_d;
			rval_q  <= rval_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// receive engine, flag, clock hold and interrupt status
	always_comb begin
		ext_d   = ext_q;
		ctrl_d  = ctrl_q;
		imask_d = imask_q;
		stat_d  = stat_q & ~{2{st_hit}}; // read clears; sets below win
		flag_d  = flag_q;
		pend_d  = pend_q;
		rbuf_d  = rbuf_q;
		shift_d = shift_q;
		cnt_d   = cnt_q;
		st_d    = st_q;
		xfer_d  = 1'b0;
		clr_c   = 1'b0;
		if (wr_go && wa == `IRH_OFF_EXT && wstb_d) begin
			ext_d = wd[7:6];
		end
		if (wr_go && wa == `IRH_OFF_CTRL && wstb_d) begin
			ctrl_d = wd[2:0];
			clr_c  = ~wd[`IRH_CTRL_EN_BIT];
		end
		if (wr_go && wa == `IRH_OFF_MASK && wstb_d) begin
			imask_d = wd[1:0];
		end
		if (wr_go && wa == `IRH_OFF_CLR && wstb_d
			&& (wd[3:0] == `IRH_CLR_CODE || wd[3:0] == `IRH_CLR_CODE_ALL)) begin
			clr_c = 1'b1;
		end
		// only receive mode runs the shifter
		rx_on   = ctrl_q[`IRH_CTRL_EN_BIT] & ~ctrl_q[`IRH_CTRL_TRS_BIT];
		rise    = scl_s_q & ~scl_p_q;
		start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
		stop_c  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
		done_c  = rx_on & rise & (cnt_q == `IRH_LAST_BIT) & (st_q == IRH_SHIFT);
		// a read in this cycle frees the buffer, so a finishing byte lands directly
		flag_eff = flag_q & ~rd_hit;
		if (rd_hit) begin
			flag_d = 1'b0;
			if (!ctrl_q[`IRH_CTRL_TRS_BIT]) begin
				xfer_d = pend_q;
				if (st_q == IRH_HOLD) begin
					st_d = IRH_SHIFT;
				end
			end
		end
		if (xfer_q) begin
			rbuf_d = shift_q;
			flag_d = 1'b1;
			pend_d = 1'b0;
		end
		case (st_q)
			IRH_IDLE: begin
				cnt_d = '0;
			end
			IRH_SHIFT: begin
				if (rise && rx_on && cnt_q < `IRH_LAST_BIT) begin
					shift_d = {shift_q[6:0], sda_s_q};
					cnt_d   = cnt_q + 4'h1;
				end
				if (done_c) begin
					cnt_d = '0;
					if (!flag_eff) begin
						rbuf_d = shift_q;
						flag_d = 1'b1;
						if (ext_q[0]) begin
							st_d = IRH_HOLD;
						end // otherwise keep shifting
					end else begin
						// overrun guard: hold until the buffer is read
						pend_d = 1'b1;
						st_d   = IRH_HOLD;
					end
				end
			end
			IRH_HOLD: begin
				cnt_d = '0;
			end
			default: begin
				st_d = IRH_IDLE;
			end
		endcase
		if (done_c) begin
			stat_d[`IRH_IRQ_RX_BIT] = 1'b1;
		end
		if (start_c && rx_on && st_q != IRH_HOLD) begin
			st_d  = IRH_SHIFT;
			cnt_d = '0;
		end
		if (stop_c && st_q != IRH_HOLD) begin
			st_d = IRH_IDLE;
		end
		// bus_irq_flag: stop in enabled slave mode unless masked
		if (stop_c && ctrl_q[`IRH_CTRL_SLV_BIT] && ctrl_q[`IRH_CTRL_EN_BIT]
			&& !ext_q[1]) begin
			stat_d[`IRH_IRQ_STOP_BIT] = 1'b1;
		end
		if (clr_c) begin
			flag_d = 1'b0;
			pend_d = 1'b0;
			xfer_d = 1'b0;
			cnt_d  = '0;
			st_d   = IRH_IDLE;
		end
		// drive scl low only once it is already low, never cut a high phase
		oe_d  = (st_d == IRH_HOLD) & (oe_q | ~scl_s_q);
		irq_d = |(stat_q & imask_q);
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ext_q   <= 2'b00;
			ctrl_q  <= `IRH_CTRL_RST;
			imask_q <= 2'b00;
			stat_q  <= 2'b00;
			flag_q  <= 1'b0;
			pend_q  <= 1'b0;
			xfer_q  <= 1'b0;
			rbuf_q  <= 8'h00;
			shift_q <= 8'h00;
			cnt_q   <= 4'h0;
			st_q    <= IRH_IDLE;
			oe_q    <= 1'b0;
			irq_q   <= 1'b0;
		end else begin
			ext_q   <= ext_d;
			ctrl_q  <= ctrl_d;
			imask_q <= imask_d;
			stat_q  <= stat_d;
			flag_q  <= flag_d;
			pend_q  <= pend_d;
			xfer_q  <= xfer_d;
			rbuf_q  <= rbuf_d;
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
			st_q    <= st_d;
			oe_q    <= oe_d;
			irq_q   <= irq_d;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = awrdy_q;
	assign s_axi_wready  = wrdy_q;
	assign s_axi_bvalid  = bval_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arrdy_q;
	assign s_axi_rvalid  = rval_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign scl_o         = 1'b0; // open drain: only the enable toggles
	assign scl_oe        = oe_q;
	assign irq           = irq_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n_q);

	chk_stop_sets_flag: assert property (
		stop_c && ctrl_q[2] && ctrl_q[0] && !ext_q[1] |=> stat_q[0] ##1 irq_q || !imask_q[0] || $past(st_hit))
		else $error("stop did not set irq flag");
	chk_stop_masked: assert property (
		stop_c && ext_q[1] && !stat_q[0] |=> !stat_q[0])
		else $error("masked stop set irq flag");
	chk_cont_no_hold: assert property (
		done_c && !flag_eff && !ext_q[0] && !clr_c |=> st_q == IRH_SHIFT && flag_q)
		else $error("continuous reception stalled");
	chk_hs_hold: assert property (
		done_c && !flag_eff && ext_q[0] && !clr_c |=> st_q == IRH_HOLD)
		else $error("handshake did not hold scl");
	chk_hold_drives: assert property (
		st_q == IRH_HOLD && !scl_s_q && !rd_hit && !clr_c |=> oe_q)
		else $error("held state did not pull scl low");
	chk_read_release: assert property (
		st_q == IRH_HOLD && rd_hit && !ctrl_q[1] && !clr_c |=> st_q != IRH_HOLD ##1 !oe_q)
		else $error("read did not release scl");
	chk_flag_load: assert property (
		done_c && !flag_eff && !clr_c |=> flag_q && rbuf_q == $past(shift_q))
		else $error("ready flag or buffer not loaded");
	chk_pend_reload: assert property (
		rd_hit && pend_q && !ctrl_q[1] && !clr_c |=> !flag_q ##1 (flag_q && !pend_q))
		else $error("pending byte not reloaded");
	chk_read_clears: assert property (
		rd_hit && !xfer_q && !done_c |=> !flag_q)
		else $error("data read left flag set");
	chk_disable_clears: assert property (
		clr_c |=> !flag_q && !pend_q && st_q == IRH_IDLE)
		else $error("clear left flag set");
	chk_tx_no_move: assert property (
		rd_hit && ctrl_q[1] && !done_c |=> rbuf_q == $past(rbuf_q) [*2])
		else $error("transmit read moved data");
endmodule

/* hdl/irh_cfg.svh */
// offsets, field positions, reset values and codes of the receive handshake block
// assumes a 32-bit axi4-lite register bus and byte addresses
`ifndef IRH_CFG_SVH
`define IRH_CFG_SVH
`define IRH_ADDR_W       8
`define IRH_OFF_EXT      8'h00
`define IRH_OFF_CTRL     8'h04
`define IRH_OFF_DATA     8'h08
`define IRH_OFF_CLR      8'h0c
`define IRH_OFF_STAT     8'h10
`define IRH_OFF_MASK     8'h14
`define IRH_EXT_MASK_BIT 7
`define IRH_EXT_HS_BIT   6
`define IRH_EXT_RDY_BIT  5
`define IRH_CTRL_EN_BIT  0
`define IRH_CTRL_TRS_BIT 1
`define IRH_CTRL_SLV_BIT 2
`define IRH_CTRL_RST     3'h0
`define IRH_IRQ_STOP_BIT 0
`define IRH_IRQ_RX_BIT   1
`define IRH_CLR_CODE     4'h5
`define IRH_CLR_CODE_ALL 4'h7
`define IRH_LAST_BIT     4'h8
`define IRH_RESP_OK      2'h0
`define IRH_RESP_ERR     2'h2
`endif

/* hdl/irh_pkg.sv */
// types shared by the receive handshake block
// assumes nothing beyond a systemverilog tool
package irh_pkg;
	// gray order: idle -> shift -> hold
	typedef enum logic [1:0] {
		IRH_IDLE  = 2'b00,
		IRH_SHIFT = 2'b01,
		IRH_HOLD  = 2'b11
	} irh_rx_st_t;
	typedef logic [31:0] irh_word_t;
endpackage

/* testbench/irh_bus_model.sv */
// two-wire bus master model: start, byte and stop on open-drain lines
// assumes pull-ups on both lines; the bench folds the block's clock hold into scl_line
module irh_bus_model (
	// levels offered, 1 = released
	output logic      scl_m,
	output logic      sda_m,
	// wired clock line as seen on the bus
	input  wire logic scl_line
);
	timeunit 1ns;
	timeprecision 100ps;
	// bus idles released, clock stands still outside frames
	initial begin
		scl_m = 1'h1;
		sda_m = 1'h1;
	end
	// one 64 ns clock pulse; a held line stretches the high phase start
	task automatic pulse(input logic b);
		sda_m = b;
		#16 scl_m = 1'h1;
		#1;
		wait (scl_line);
		#3;
		#28 scl_m = 1'h0;
		#16;
	endtask
	// start, repeated start included; waits out a held clock first
	task automatic start();
		#3 sda_m = 1'h1;
		#16 scl_m = 1'h1;
		#1;
		wait (scl_line);
		#3;
		#28 sda_m = 1'h0;
		#32 scl_m = 1'h0;
		#16;
	endtask
	// eight bits msb first, then a ninth pulse with sda released
	task automatic send(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			pulse(d[i]);
		end
		pulse(1'h1);
	endtask
	// stop: sda rises while scl is high
	task automatic stop();
		sda_m = 1'h0;
		#16 scl_m = 1'h1;
		#1;
		wait (scl_line);
		#3;
		#28 sda_m = 1'h1;
		#32;
	endtask
endmodule

/* testbench/irh_top_bench.sv */
// self-checking bench of the receive handshake block
// assumes the bus model is the only master on scl and sda, both pulled up
`include "irh_cfg.svh"
module irh_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import irh_pkg::*;
	logic       sys_clk = 1'h0;
	logic       nrst = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	irh_word_t  s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic       s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic       s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic       scl_o, scl_oe, irq, scl_m, sda_m;
	wire logic  scl_line = scl_m & ~(scl_oe & ~scl_o);
	int         n_fail = 0, check_count = 0, cyc = 0, seed = 32'hf7da3007;
	logic [33:0] exp_q[$];
	logic [7:0] b1, b2;
	irh_top i_irh_top (
		.sys_clk       (sys_clk),
		.nrst          (nrst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.scl_i         (scl_line),
		.scl_o         (scl_o),
		.scl_oe        (scl_oe),
		.sda_i         (sda_m),
		.irq           (irq)
	);
	irh_bus_model i_irh_bus_model (.scl_m(scl_m), .sda_m(sda_m), .scl_line(scl_line));
	// 125 MHz system clock
	initial forever #4 sys_clk = ~sys_clk;
	task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// the oldest note is matched to each answer the slave hands over
	always @(posedge sys_clk) begin
		if (s_axi_bvalid && s_axi_bready) chk("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
		if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
	end
	// a hung handshake or held clock ends the run here
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input irh_word_t d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input irh_word_t d, input logic [1:0] r = 2'h0);
		exp_q.push_back({r, d});
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'h0;
	endtask
	// one framed random byte from the master
	task automatic rx(output logic [7:0] b);
		b = 8'($random(seed));
		i_irh_bus_model.start();
		i_irh_bus_model.send(b);
	endtask
	// pins settle a few cycles after the bus event, so look later
	task automatic see(input logic e, input bit which);
		repeat (6) @(posedge sys_clk);
		if (which) chk("irq", {33'h0, irq}, {33'h0, e});
		else chk("scl_oe", {33'h0, scl_oe}, {33'h0, e});
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		nrst <= 1'h1;
		// reset values, read-only bit, unmapped and read-only places
		rd(`IRH_OFF_EXT, 32'h0);
		rd(`IRH_OFF_CTRL, 32'h0);
		rd(`IRH_OFF_MASK, 32'h0);
		rd(`IRH_OFF_CLR, 32'hf);
		rd(8'h18, 32'h0, `IRH_RESP_ERR);
		wr(8'h18, 32'hff, `IRH_RESP_ERR);
		wr(`IRH_OFF_DATA, 32'hff, `IRH_RESP_ERR);
		wr(`IRH_OFF_EXT, 32'h20, `IRH_RESP_OK);
		rd(`IRH_OFF_EXT, 32'h0);
		// a write with lane 0 disabled leaves the register alone
		s_axi_wstrb <= 4'he;
		wr(`IRH_OFF_EXT, 32'hc0, `IRH_RESP_OK);
		s_axi_wstrb <= 4'hf;
		rd(`IRH_OFF_EXT, 32'h0);
		// continuous reception in slave receive mode
		wr(`IRH_OFF_CTRL, 32'h5, `IRH_RESP_OK);
		rx(b1);
		see(1'h0, 1'b0);
		rd(`IRH_OFF_EXT, 32'h20);
		rd(`IRH_OFF_DATA, {24'h0, b1});
		rd(`IRH_OFF_EXT, 32'h0);
		// second byte finishes while the flag is still set, so it waits pending with scl held
		rx(b1);
		rx(b2);
		see(1'h1, 1'b0);
		rd(`IRH_OFF_DATA, {24'h0, b1});
		rd(`IRH_OFF_EXT, 32'h20);
		rd(`IRH_OFF_DATA, {24'h0, b2});
		// handshake: next transfer blocked until the byte is read
		wr(`IRH_OFF_EXT, 32'h40, `IRH_RESP_OK);
		rx(b1);
		see(1'h1, 1'b0);
		fork
			rx(b2);
		join_none
		repeat (40) @(posedge sys_clk);
		rd(`IRH_OFF_EXT, 32'h60);
		rd(`IRH_OFF_DATA, {24'h0, b1});
		wait fork;
		rd(`IRH_OFF_DATA, {24'h0, b2});
		see(1'h0, 1'b0);
		// a read in transmit mode leaves the pending byte where it is
		wr(`IRH_OFF_EXT, 32'h0, `IRH_RESP_OK);
		rx(b1);
		rx(b2);
		wr(`IRH_OFF_CTRL, 32'h7, `IRH_RESP_OK);
		rd(`IRH_OFF_DATA, {24'h0, b1});
		rd(`IRH_OFF_EXT, 32'h0);
		wr(`IRH_OFF_CTRL, 32'h0, `IRH_RESP_OK);
		// enable low and both clear codes drop a set flag
		for (int i = 0; i < 3; i++) begin
			wr(`IRH_OFF_CTRL, 32'h5, `IRH_RESP_OK);
			rx(b1);
			rd(`IRH_OFF_EXT, 32'h20);
			if (i == 0) wr(`IRH_OFF_CTRL, 32'h4, `IRH_RESP_OK);
			else wr(`IRH_OFF_CLR, {28'h0, i == 1 ? `IRH_CLR_CODE : `IRH_CLR_CODE_ALL}, `IRH_RESP_OK);
			rd(`IRH_OFF_EXT, 32'h0);
		end
		// byte status is masked; stop interrupts unmasked, then stop mask set
		wr(`IRH_OFF_MASK, 32'h1, `IRH_RESP_OK);
		see(1'h0, 1'b1);
		rd(`IRH_OFF_STAT, 32'h2);
		for (int i = 0; i < 2; i++) begin
			wr(`IRH_OFF_EXT, i ? 32'h80 : 32'h0, `IRH_RESP_OK);
			i_irh_bus_model.start();
			i_irh_bus_model.stop();
			see(i == 0, 1'b1);
			rd(`IRH_OFF_STAT, i ? 32'h0 : 32'h1);
		end
		see(1'h0, 1'b1);
		results();
	end
endmodule
